// [hw/src_pkg.sv]
package src_pkg;

  // display geometry
  localparam int unsigned DOTS_PER_CHAR   = 9;
  localparam int unsigned CHARS_PER_ROW   = 97;
  localparam int unsigned VISIBLE_CHARS   = 80;
  localparam int unsigned ROWS_ADDRESSED  = 11;
  localparam int unsigned ROW_CURSOR      = 12;    // zero based index of row 13
  localparam int unsigned ROWS_PLAIN      = 12;
  localparam int unsigned ROWS_CURSOR     = 13;
  localparam int unsigned SCREEN_CHARS    = 1920;
  localparam int unsigned CMD_LINE        = 24;    // partial line after 24 text lines
  localparam int unsigned ADDR_W          = 11;    // counts up to 2047

  // strobe phases within one character time (dot index)
  localparam logic [3:0] PH_RESET_CLK = 4'h0;
  localparam logic [3:0] PH_MEM_CLK   = 4'h1;
  localparam logic [3:0] PH_READ_EN   = 4'h2;
  localparam logic [3:0] PH_OBUF_LD   = 4'h3;
  localparam logic [3:0] PH_DBUF_LD   = 4'h4;
  localparam logic [3:0] PH_LAST      = 4'h8;

  // clock and timing
  localparam real         CLK_MHZ           = 10.0;
  localparam real         OSC_MHZ           = 13.482;  // original dot oscillator
  localparam real         SCREEN_PERIOD_MS  = 20.0;
  localparam real         MEM_REFRESH_US    = 15.6;    // per row address, longest
  localparam int unsigned MEM_REFRESH_CYC   = int'($floor(MEM_REFRESH_US * CLK_MHZ));
  localparam int unsigned MEM_ROW_W         = 7;       // 128 row addresses
  localparam int unsigned BLINK_FRAMES      = 16;

  // job definition byte fields
  localparam int unsigned JOB_DATA_MODE     = 0;
  localparam int unsigned JOB_LOWINT_FIXED  = 1;
  localparam int unsigned JOB_LOWINT_VAR    = 2;
  localparam int unsigned JOB_SHOW_CTL      = 3;
  localparam int unsigned JOB_BLANK_CMD     = 4;
  // field definition byte / control code fields
  localparam int unsigned FLD_BLANK         = 0;
  localparam int unsigned FLD_BLINK         = 1;
  localparam int unsigned FLD_TYPE_LO       = 3;
  localparam int unsigned FLD_TYPE_HI       = 4;
  localparam int unsigned FLD_LOWERCASE     = 5;
  localparam logic [1:0]  FLD_TYPE_FIXED    = 2'h0;
  localparam logic [1:0]  CTL_CODE_TAG      = 2'h0;    // bits 7:6 of a control code

  // display timing from the display counters
  typedef struct packed {
    logic [3:0] dot;
    logic [6:0] chr;
    logic [3:0] row;
    logic [4:0] line;
  } src_timing_s;

  // processor access request
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } src_rw_req_s;

  // video attribute flags
  typedef struct packed {
    logic blank_field;
    logic blank_ctl;
    logic blink_field;
    logic blank_cmd;
    logic low_intensity;
    logic variable_field;
  } src_vflags_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_STROBE = 3'b010,
    ST_DONE   = 3'b011,
    ST_MREF   = 3'b100
  } src_state_e;

endpackage

// [hw/src_screen_refresh_control.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - five refresh strobes per character, per row
// - full screen repeats about every 20 ms
// - read enable, output and display loads
// - 1920 sequential addresses, 11-bit counter
// - line start steps 80, loaded each row
// - same 80 addresses for 11 rows
// - processor access placed in retrace time
// - refresh inhibit gives processor access priority
// - processor access drives B register address
// - inhibit without access runs memory refresh
// - cursor video on address match
// - cursor video delayed two character times
// - cursor line raises cursor enable flag
// - cursor video only during row 13
// - blink timing passed to video control
// - bits 7:6 low mark control code
// - bits 4:3 classify fixed or variable
// - blank, blink, command area, intensity flags
// - field blank and intensity need data mode
// - case shift permit low on mode+lowercase
// - permit low allows lower case entry
// - field definition register holds cursor byte
// - 97 character times of nine dots
// - 12 rows, 13 with cursor enable
// - single synchronous clock for all timing
module src_screen_refresh_control
  import src_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 2,
  parameter int unsigned DATA_W     = 8
)(
  input  wire logic              clk_i,                  // single system clock
  input  wire logic              srst_i,                 // sync reset, high
  input  wire src_timing_s       timing_i,               // display counter state
  input  wire logic              screen_refresh_inhibit_i, // processor inhibits refresh
  input  wire logic              rw_req_i,               // processor access request
  input  wire src_rw_req_s       rw_i,                   // access kind, B reg address, data
  input  wire logic              cursor_load_i,          // store B reg as cursor
  input  wire logic [ADDR_W-1:0] b_reg_i,                // B register
  input  wire logic [7:0]        job_def_i,              // job definition byte
  input  wire logic              field_def_load_i,       // byte passed by cursor
  input  wire logic [7:0]        field_definition_byte_i, // that byte
  input  wire logic [7:0]        mem_rdata_i,            // refresh memory data out
  input  wire logic              disp_ready_i,           // display path accepts
  output logic                   reset_clk_n_o,          // memory shift reset clock
  output logic                   refresh_memory_clock_n_o, // memory clock
  output logic                   read_en_n_o,            // memory to output buffer
  output logic                   output_buffer_load_n_o, // output buffer load
  output logic                   display_buffer_load_n_o, // display buffer load
  output logic [ADDR_W-1:0]      mem_addr_o,             // refresh memory address
  output logic                   mem_we_n_o,             // memory write strobe
  output logic [7:0]             mem_wdata_o,            // memory write data
  output logic                   mem_refresh_n_o,        // dynamic refresh cycle
  output logic                   rw_ack_o,               // processor access done
  output logic [7:0]             rw_rdata_o,             // processor read data
  output logic                   disp_valid_o,           // display word valid
  output logic [DATA_W-1:0]      disp_data_o,            // display word
  output logic                   cursor_enable_o,        // counter counts row 13
  output logic                   cursor_video_o,         // cursor painting
  output src_vflags_s            vflags_o,               // video attribute flags
  output logic                   case_shift_permit_n_o,  // lower case allowed, low
  output logic                   frame_tick_o            // start of each screen while refresh is not inhibited
);

  ////////////////////////////////////////////////////////////////////////////////
  // timing decode
  logic visible_row;
  logic visible_chr;
  logic char_slot;
  logic row_start;
  logic frame_start;
  logic line_end;
  logic retrace;
  logic char_end;

  // strobes only on the 80 visible characters of the first 11 rows
  assign visible_row = (timing_i.row < 4'(ROWS_ADDRESSED));
  assign visible_chr = (timing_i.chr < 7'(VISIBLE_CHARS));
  assign char_slot   = visible_row & visible_chr;
  assign char_end    = (timing_i.dot == PH_LAST);
  assign row_start   = (timing_i.chr == 7'h00) & (timing_i.dot == 4'h0);
  assign frame_start = row_start & (timing_i.row == 4'h0) & (timing_i.line == 5'h00);
  // last character of the last row of a line; row count depends on cursor enable
  assign line_end    = char_end & (timing_i.chr == 7'(CHARS_PER_ROW - 1)) &
                       (timing_i.row == (cursor_enable_o ? 4'(ROWS_CURSOR - 1)
                                                         : 4'(ROWS_PLAIN - 1)));
  // dead time, less the last char so an access ends before the next fetch
  assign retrace     = ~char_slot & (timing_i.chr != 7'(CHARS_PER_ROW - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // refresh strobes, one set per character per row
  logic obuf_fire;
  logic obuf_pend_q;
  logic fifo_in_ready;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reset_clk_n_o            <= 1'b1;
      refresh_memory_clock_n_o <= 1'b1;
      read_en_n_o              <= 1'b1;
      output_buffer_load_n_o   <= 1'b1;
      display_buffer_load_n_o  <= 1'b1;
    end
    else
    begin
      // inhibit suspends the whole refresh sequence
      reset_clk_n_o            <= ~(char_slot & ~screen_refresh_inhibit_i &
                                    timing_i.dot == PH_RESET_CLK);
      refresh_memory_clock_n_o <= ~(char_slot & ~screen_refresh_inhibit_i &
                                    timing_i.dot == PH_MEM_CLK);
      read_en_n_o              <= ~(char_slot & ~screen_refresh_inhibit_i &
                                    timing_i.dot == PH_READ_EN);
      output_buffer_load_n_o   <= ~obuf_fire;
      display_buffer_load_n_o  <= ~(char_slot & ~screen_refresh_inhibit_i &
                                    timing_i.dot == PH_DBUF_LD);
    end
  end

  assign obuf_fire = char_slot & ~screen_refresh_inhibit_i & (timing_i.dot == PH_OBUF_LD);

  // frame marker: one pulse per screen unless refresh is inhibited, about every 20 ms at the nominal rate
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      frame_tick_o <= 1'b0;
    else
      frame_tick_o <= frame_start & ~screen_refresh_inhibit_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // video address generation
  logic [ADDR_W-1:0] line_start_q;
  logic [ADDR_W-1:0] vid_addr_q;

  // line start value: cleared per screen, steps by 80 per character line
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      line_start_q <= '0;
    else if (frame_start)
      line_start_q <= '0;
    else if (line_end)
      line_start_q <= line_start_q + ADDR_W'(VISIBLE_CHARS);
  end

  // address counter: reloaded per row, advances once per character
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      vid_addr_q <= '0;
    else if (row_start)
      vid_addr_q <= frame_start ? '0 : line_start_q;
    else if (char_slot & char_end)
      vid_addr_q <= vid_addr_q + ADDR_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // processor access and memory refresh sequencer
  src_state_e         state_q;
  src_rw_req_s        rw_q;
  logic [MEM_ROW_W-1:0] mref_row_q;
  logic [15:0]        mref_cnt_q;
  logic               mref_due;
  logic               rw_window;

  // access may start in dead time or at any time while refresh is inhibited
  assign rw_window = retrace | screen_refresh_inhibit_i;
  assign mref_due  = (mref_cnt_q >= 16'(MEM_REFRESH_CYC - 2));

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (rw_req_i & rw_window)
            state_q <= ST_ADDR;
          else if (screen_refresh_inhibit_i & mref_due)
            state_q <= ST_MREF;
        end
        ST_ADDR:   state_q <= ST_STROBE;
        ST_STROBE: state_q <= ST_DONE;
        ST_DONE:   state_q <= ST_IDLE;
        ST_MREF:   state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // request captured when accepted
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rw_q <= '0;
    else if (state_q == ST_IDLE & rw_req_i & rw_window)
      rw_q <= rw_i;
  end

  // refresh interval counter; restarts after each refresh cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mref_cnt_q <= '0;
    else if (state_q == ST_MREF | ~screen_refresh_inhibit_i)
      mref_cnt_q <= '0;
    else if (~mref_due)
      mref_cnt_q <= mref_cnt_q + 16'h0001;
  end

  // refresh row walks all row addresses in turn
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mref_row_q <= '0;
    else if (state_q == ST_MREF)
      mref_row_q <= mref_row_q + MEM_ROW_W'(1);
  end

  // memory address mux: processor address blocks the video address
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mem_addr_o      <= '0;
      mem_we_n_o      <= 1'b1;
      mem_wdata_o     <= '0;
      mem_refresh_n_o <= 1'b1;
    end
    else
    begin
      if (state_q == ST_ADDR | state_q == ST_STROBE | state_q == ST_DONE)
        mem_addr_o <= rw_q.addr;
      else if (state_q == ST_MREF)
        mem_addr_o <= ADDR_W'(mref_row_q);
      else
        mem_addr_o <= vid_addr_q;
      mem_we_n_o      <= ~(state_q == ST_STROBE & rw_q.write);
      mem_wdata_o     <= rw_q.data;
      mem_refresh_n_o <= ~(state_q == ST_MREF);
    end
  end

  // processor answer: one pulse, read data sampled at the end of the cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rw_ack_o   <= 1'b0;
      rw_rdata_o <= '0;
    end
    else
    begin
      rw_ack_o <= (state_q == ST_DONE);
      if (state_q == ST_DONE & ~rw_q.write)
        rw_rdata_o <= mem_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // two-entry display buffer; a stalled receiver holds the word pending
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [DATA_W-1:0] pend_data_q;
  logic              rd_ptr_q;
  logic              wr_ptr_q;
  logic [1:0]        count_q;
  logic              push;
  logic              pop;
  logic              out_valid;

  assign fifo_in_ready = (count_q != 2'(FIFO_DEPTH));
  assign push          = obuf_pend_q & fifo_in_ready;
  assign out_valid     = (count_q != 2'h0);
  assign pop           = out_valid & disp_ready_i;

  // the output buffer word waits here until the buffer has room
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      obuf_pend_q <= 1'b0;
      pend_data_q <= '0;
    end
    else if (obuf_fire)
    begin
      obuf_pend_q <= 1'b1;
      pend_data_q <= DATA_W'(mem_rdata_i);
    end
    else if (push)
      obuf_pend_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      fifo_mem[wr_ptr_q] <= pend_data_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end

  // registered view of the buffer head
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      disp_valid_o <= 1'b0;
      disp_data_o  <= '0;
    end
    else
    begin
      disp_valid_o <= (count_q - 2'(pop) + 2'(push)) != 2'h0;
      disp_data_o  <= (count_q - 2'(pop) == 2'h0) ? pend_data_q
                                                 : fifo_mem[rd_ptr_q ^ pop];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cursor buffer and compare
  logic [ADDR_W-1:0] cursor_addr_q;
  logic [1:0]        match_dly_q;
  logic              row13_q;
  logic [4:0]        blink_cnt_q;
  logic              blink_q;
  logic              on_line;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cursor_addr_q <= '0;
    else if (cursor_load_i)
      cursor_addr_q <= b_reg_i;
  end

  // match on line start plus column, valid in row 13; two char delay
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      match_dly_q <= 2'h0;
    else if (char_end)
      match_dly_q <= {match_dly_q[0],
                      visible_chr &
                      (line_start_q + ADDR_W'(timing_i.chr) == cursor_addr_q)};
  end

  // cursor sits on the line whose 80 addresses start at line start
  assign on_line = (cursor_addr_q >= line_start_q) &
                   (cursor_addr_q <  line_start_q + ADDR_W'(VISIBLE_CHARS));

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cursor_enable_o <= 1'b0;
    else
      cursor_enable_o <= on_line & (cursor_addr_q < ADDR_W'(SCREEN_CHARS));
  end

  // cursor video enable opens at the start of row 13
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      row13_q <= 1'b0;
    else if (row_start)
      row13_q <= (timing_i.row == 4'(ROW_CURSOR)) & cursor_enable_o;
  end

  // blink timing: toggles every few screens
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end
    else if (frame_start)
    begin
      if (blink_cnt_q == 5'(BLINK_FRAMES - 1))
      begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cursor_video_o <= 1'b0;
    else
      cursor_video_o <= match_dly_q[1] & row13_q &
                        (timing_i.row == 4'(ROW_CURSOR));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // video control
  logic [7:0] field_def_q;
  logic [7:0] ctl_q;
  logic       is_ctl;
  logic       data_mode;
  logic       var_field;

  // only the byte the cursor passed is kept here, not the streamed ones
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      field_def_q <= '0;
    else if (field_def_load_i)
      field_def_q <= field_definition_byte_i;
  end

  assign is_ctl    = (mem_rdata_i[7:6] == CTL_CODE_TAG);
  assign data_mode = job_def_i[JOB_DATA_MODE];
  assign var_field = (ctl_q[FLD_TYPE_HI:FLD_TYPE_LO] != FLD_TYPE_FIXED);

  // latest control code seen in the refresh stream, cleared per screen
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ctl_q <= '0;
    else if (frame_start)
      ctl_q <= '0;
    else if (obuf_fire & is_ctl)
      ctl_q <= mem_rdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      vflags_o <= '0;
    else
    begin
      vflags_o.variable_field <= var_field;
      vflags_o.blank_field    <= data_mode & ctl_q[FLD_BLANK];
      vflags_o.blank_ctl      <= obuf_fire & is_ctl & ~job_def_i[JOB_SHOW_CTL];
      vflags_o.blink_field    <= ctl_q[FLD_BLINK] & blink_q;
      vflags_o.blank_cmd      <= job_def_i[JOB_BLANK_CMD] &
                                 (timing_i.line == 5'(CMD_LINE));
      vflags_o.low_intensity  <= data_mode &
                                 (var_field ? job_def_i[JOB_LOWINT_VAR]
                                            : job_def_i[JOB_LOWINT_FIXED]);
    end
  end

  // low permits lower case keyboard entry
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      case_shift_permit_n_o <= 1'b1;
    else
      case_shift_permit_n_o <= ~(data_mode & field_def_q[FLD_LOWERCASE]);
  end

endmodule

// [test/src_chk.sv]
`timescale 1ns/10ps
module src_chk
  import src_pkg::*;
(
  input wire logic              clk_i,                    // clock
  input wire logic              srst_i,                   // reset
  input wire src_timing_s       timing_i,                 // counters
  input wire logic              screen_refresh_inhibit_i, // inhibit
  input wire logic              rw_req_i,                 // request
  input wire src_rw_req_s       rw_i,                     // access
  input wire logic              reset_clk_n_o,            // strobe
  input wire logic              refresh_memory_clock_n_o, // strobe
  input wire logic              read_en_n_o,              // strobe
  input wire logic              output_buffer_load_n_o,   // strobe
  input wire logic              display_buffer_load_n_o,  // strobe
  input wire logic [ADDR_W-1:0] mem_addr_o,               // address
  input wire logic              mem_we_n_o,               // write
  input wire logic              mem_refresh_n_o,          // refresh
  input wire logic              rw_ack_o,                 // done
  input wire logic              cursor_video_o            // cursor
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // visible refresh slot: addressed row, visible char, not inhibited
  logic vis;
  assign vis = timing_i.row < ROWS_ADDRESSED && timing_i.chr < VISIBLE_CHARS
               && !screen_refresh_inhibit_i;

  a_reset_clk_phase: assert property (vis && timing_i.dot == PH_RESET_CLK |=> !reset_clk_n_o)
    else $error("reset clock strobe missing");
  a_mem_clk_phase: assert property (vis && timing_i.dot == PH_MEM_CLK |=>
    !refresh_memory_clock_n_o)
    else $error("memory clock strobe missing");
  a_read_en_phase: assert property (vis && timing_i.dot == PH_READ_EN |=> !read_en_n_o)
    else $error("read enable missing");
  a_obuf_phase: assert property (vis && timing_i.dot == PH_OBUF_LD |=>
    !output_buffer_load_n_o)
    else $error("output buffer load missing");
  a_dbuf_phase: assert property (vis && timing_i.dot == PH_DBUF_LD |=>
    !display_buffer_load_n_o)
    else $error("display buffer load missing");
  a_read_en_window: assert property (!read_en_n_o |->
    $past(vis) && $past(timing_i.dot) == PH_READ_EN)
    else $error("read enable outside a refresh slot");
  a_ack_after_four: assert property (rw_ack_o |-> $past(rw_req_i, 4) &&
    $past(mem_addr_o, 2) == $past(rw_i.addr, 4))
    else $error("access ack or address wrong");
  a_write_only: assert property (!mem_we_n_o |-> $past(rw_req_i, 2) && $past(rw_i.write, 2))
    else $error("write strobe without write request");
  a_refresh_inhibit: assert property (!mem_refresh_n_o |-> $past(screen_refresh_inhibit_i))
    else $error("memory refresh while screen refresh runs");
  a_cursor_row13: assert property (cursor_video_o |-> $past(timing_i.row) == ROW_CURSOR)
    else $error("cursor video outside the cursor row");

  c_rw_done: cover property (rw_ack_o);
  c_mem_refresh: cover property (!mem_refresh_n_o);
  c_cursor: cover property (cursor_video_o);
endmodule

bind src_screen_refresh_control src_chk i_src_chk (.*);

// [test/src_mem_model.sv]
`timescale 1ns/10ps
module src_mem_model
  import src_pkg::*;
(
  input  wire logic              clk_i,   // system clock
  input  wire logic [ADDR_W-1:0] addr_i,  // memory address
  input  wire logic              we_n_i,  // write, low
  input  wire logic [7:0]        wdata_i, // write data
  output logic [7:0]             rdata_o, // read data
  input  wire logic              stall_i, // stall wish
  output logic                   ready_o  // display ready
);
  logic [7:0] mem [2**ADDR_W];

  // preset pattern lets the bench predict every refresh word
  initial
  begin
    rdata_o = 8'h00;
    for (int a = 0; a < 2**ADDR_W; a++)
      mem[a] = 8'(a * 7);
  end

  // storage answers one clock after the address, no faster
  always @(posedge clk_i)
  begin
    if (!we_n_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end

  // display stalls only as the bench commands
  assign ready_o = !stall_i;
endmodule

// [test/src_screen_refresh_control_tb.sv]
`timescale 1ns/10ps
module src_screen_refresh_control_tb;
  import src_pkg::*;
  logic              clk_i, srst_i, screen_refresh_inhibit_i, rw_req_i, cursor_load_i;
  logic              field_def_load_i, disp_ready_i, disp_valid_o, stall, chk_words, saw_cen;
  logic              reset_clk_n_o, refresh_memory_clock_n_o, read_en_n_o, rst_seen;
  logic              output_buffer_load_n_o, display_buffer_load_n_o, mem_we_n_o;
  logic              mem_refresh_n_o, rw_ack_o, cursor_enable_o, cursor_video_o;
  logic              case_shift_permit_n_o, frame_tick_o;
  src_timing_s       timing_i;
  src_rw_req_s       rw_i;
  src_vflags_s       vflags_o;
  logic [ADDR_W-1:0] b_reg_i, mem_addr_o;
  logic [7:0]        job_def_i, field_definition_byte_i, mem_rdata_i, mem_wdata_o;
  logic [7:0]        rw_rdata_o, disp_data_o, q;
  logic [7:0]        dat [4];
  logic [ADDR_W-1:0] adr [4];
  logic [31:0]       rnd, rs;
  int                n_mismatch, checks_done, nword, ncv, n, k;

  src_screen_refresh_control i_src_screen_refresh_control (.*);
  src_mem_model i_src_mem_model (
    .clk_i   (clk_i),
    .addr_i  (mem_addr_o),
    .we_n_i  (mem_we_n_o),
    .wdata_i (mem_wdata_o),
    .rdata_o (mem_rdata_i),
    .stall_i (stall),
    .ready_o (disp_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // word n of the screen: line start plus column, rows repeat
  function automatic logic [7:0] exp_word(input int n);
    int a;
    a = VISIBLE_CHARS * (n / (VISIBLE_CHARS * ROWS_ADDRESSED)) + n % VISIBLE_CHARS;
    return 8'(a * 7);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // held request until ack shows, then drop it in the ack cycle
  task automatic rw_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    #1;
    rw_i = '{write: wr, addr: a, data: d};
    rw_req_i = 1'b1;
    for (i = 0; i < 3000 && rw_ack_o !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    q = rw_rdata_o;
    rw_req_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // display counters and random stalls; the stall ends by dot 5 so no word is lost
  always @(posedge clk_i)
  begin
    rst_seen = srst_i;
    #1;
    rnd = lfsr(rnd);
    stall = rnd[0] && timing_i.dot < 4'h5;
    if (rst_seen)
      timing_i = '0;
    else if (timing_i.dot != PH_LAST)
      timing_i.dot += 4'h1;
    else
    begin
      timing_i.dot = '0;
      if (timing_i.chr != 7'(CHARS_PER_ROW - 1))
        timing_i.chr += 7'h01;
      else
      begin
        timing_i.chr = '0;
        if (timing_i.row != 4'((cursor_enable_o ? ROWS_CURSOR : ROWS_PLAIN) - 1))
          timing_i.row += 4'h1;
        else
        begin
          timing_i.row = '0;
          timing_i.line += 5'h01;
        end
      end
    end
  end

  // watch accepted words and cursor activity
  always @(posedge clk_i)
  begin
    if (chk_words && disp_valid_o === 1'b1 && disp_ready_i === 1'b1)
    begin
      cmp(disp_data_o, exp_word(nword));
      nword++;
    end
    if (cursor_video_o === 1'b1)
      ncv++;
    if (cursor_enable_o === 1'b1)
      saw_cen = 1'b1;
  end

  // limit well past the expected run of about 34k cycles
  initial
  begin
    #8_000_000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    {srst_i, screen_refresh_inhibit_i, rw_req_i, cursor_load_i} = 4'h8;
    {field_def_load_i, stall, chk_words, saw_cen} = 4'h0;
    {b_reg_i, job_def_i, field_definition_byte_i} = '0;
    rw_i = '0;
    timing_i = '0;
    rnd = 32'h2b0b_e620;
    rs = rnd;
    repeat (16) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    cursor_load_i = 1'b1;
    b_reg_i = 11'(VISIBLE_CHARS + 5);
    chk_words = 1'b1;
    @(posedge clk_i);
    #1;
    cursor_load_i = 1'b0;
    while (timing_i.line != 5'h03)
      @(posedge clk_i);
    #1;
    chk_words = 1'b0;
    cmp(nword, 3 * VISIBLE_CHARS * ROWS_ADDRESSED);
    cmp(ncv, DOTS_PER_CHAR);
    cmp(saw_cen, 1'b1);
    $display("screen refresh test done");
    // writes under inhibit, reads back in retrace; both ends of the screen
    screen_refresh_inhibit_i = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      rs = lfsr(rs);
      adr[k] = k == 0 ? '0 : k == 3 ? 11'(SCREEN_CHARS - 1) : 11'(rs[15:0] % 1900 + 1);
      dat[k] = rs[23:16];
      rw_op(1'b1, adr[k], dat[k]);
    end
    screen_refresh_inhibit_i = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      rw_op(1'b0, adr[k], 8'h00);
      cmp(q, dat[k]);
    end
    $display("access test done");
    // idle inhibit: refresh cycles at a fixed spacing
    screen_refresh_inhibit_i = 1'b1;
    repeat (200) @(posedge clk_i);
    n = 0;
    repeat (3 * MEM_REFRESH_CYC)
    begin
      @(posedge clk_i);
      #1;
      if (mem_refresh_n_o === 1'b0)
        n++;
    end
    cmp(n, 3);
    $display("memory refresh test done");
    // every data mode and lowercase combination
    for (k = 0; k < 4; k++)
    begin
      job_def_i = 8'(k % 2);
      field_definition_byte_i = 8'((k / 2) << FLD_LOWERCASE);
      field_def_load_i = 1'b1;
      @(posedge clk_i);
      #1;
      field_def_load_i = 1'b0;
      repeat (3) @(posedge clk_i);
      cmp(case_shift_permit_n_o, k != 3);
    end
    $display("case shift test done");
    conclude();
  end
endmodule
